// ==== verilog/nvw_pkg.sv ====
// constants and carrier types for the wiper memory block
package nvw_pkg;
    localparam logic [7:0] WIDE_WIPER_OFS   = 8'hf8;
    localparam logic [7:0] NARROW_WIPER_OFS = 8'hf9;
    localparam logic [7:0] REGION_SEL_OFS   = 8'hfa;
    localparam logic [7:0] LOCK_KEY1_OFS    = 8'hfb;
    localparam logic [7:0] LOCK_KEY2_OFS    = 8'hfc;
    localparam logic [7:0] USER_LAST        = 8'hf7;
    localparam logic [7:0] LOWER_LAST       = 8'h7f;
    localparam logic [7:0] NARROW_MAX       = 8'h63;
    localparam logic [7:0] LOCK_PAT1        = 8'h56;
    localparam logic [7:0] LOCK_PAT2        = 8'h25;
    localparam logic [7:0] UNLOCK_PAT1      = 8'h67;
    localparam logic [7:0] UNLOCK_PAT2      = 8'h36;
    localparam logic [3:0] DEV_TYPE         = 4'ha;
    localparam int         GUARD_PAGE_BIT   = 2;
    localparam int         GUARD_UPPER_BIT  = 1;
    localparam int         GUARD_LOWER_BIT  = 0;
    localparam int         PAGE_BYTES       = 8;
    localparam int         WRITE_TIME_US    = 10;
    localparam int         CLK_MHZ          = 100;
    localparam int         WRITE_CYCLES     = WRITE_TIME_US * CLK_MHZ;
    localparam logic [7:0] ERASED_BYTE      = 8'hff;

    // one staged page byte
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } nvw_word_t;

    typedef enum logic [2:0] {
        NVW_IDLE,
        NVW_DEVADDR,
        NVW_WORDADDR,
        NVW_WDATA,
        NVW_RDATA,
        NVW_RACK,
        NVW_IGNORE
    } nvw_state_t;
endpackage

// ==== verilog/nvw_top.sv ====
// two-wire slave fronting a byte array with two wiper settings
`timescale 1ns/1ps
module nvw_top #(
    parameter int WRITE_CYCLES = nvw_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    // two-wire link
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // strap and protect pins
    input  wire logic       addr_select_bit0,
    input  wire logic       addr_select_bit1,
    input  wire logic       addr_select_bit2,
    input  wire logic       write_protect,
    // wiper settings
    output logic [6:0]      narrow_wiper_out,
    output logic [7:0]      wide_wiper_out,
    // status
    output logic            standby,
    output logic            write_busy
);

    //--------------------------------------------------------------
    // pin synchronisers and edge detection
    //--------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q, wp_sync_q;
    logic [2:0] sel_sync1_q, sel_sync2_q;
    logic       scl_prev_q, sda_prev_q;
    logic       scl_rise, scl_fall, start_det, stop_det;

    // two flip-flops on every outside input but reset
    always_ff @(posedge sys_clk)
    begin
        scl_sync_q  <= {scl_sync_q[0], scl_in};
        sda_sync_q  <= {sda_sync_q[0], sda_in};
        wp_sync_q   <= {wp_sync_q[0], write_protect};
        sel_sync1_q <= {addr_select_bit2, addr_select_bit1,
                        addr_select_bit0};
        sel_sync2_q <= sel_sync1_q;
        if (!rstn)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign scl_rise  = scl_sync_q[1] & ~scl_prev_q;
    assign scl_fall  = ~scl_sync_q[1] & scl_prev_q;
    // data edges while clock stays high are bus conditions
    assign start_det = scl_sync_q[1] & scl_prev_q
                     & sda_prev_q & ~sda_sync_q[1];
    assign stop_det  = scl_sync_q[1] & scl_prev_q
                     & ~sda_prev_q & sda_sync_q[1];

    //--------------------------------------------------------------
    // storage
    //--------------------------------------------------------------
    logic [7:0]         mem_q [256];
    logic [7:0]         word_addr_q;
    logic               locked_q;
    nvw_pkg::nvw_word_t page_q [nvw_pkg::PAGE_BYTES];
    logic [3:0]         page_cnt_q;
    logic [15:0]        busy_cnt_q;
    logic               committing;

    // protection lookup by address, used at commit for array and wipers
    function automatic logic is_guarded(input logic [7:0] a,
                                        input logic [7:0] sel,
                                        input logic       lk);
        logic g;
        g = 1'b0;
        if (a > nvw_pkg::USER_LAST)
            g = sel[nvw_pkg::GUARD_PAGE_BIT];
        else if (a > nvw_pkg::LOWER_LAST)
            g = sel[nvw_pkg::GUARD_UPPER_BIT];
        else
            g = sel[nvw_pkg::GUARD_LOWER_BIT];
        return g & lk;
    endfunction

    //--------------------------------------------------------------
    // protocol state
    //--------------------------------------------------------------
    nvw_pkg::nvw_state_t state_q;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic        ack_phase_q;
    logic        read_seq_q;
    logic        sda_drive_q;
    logic        wp_q;
    logic [7:0]  rd_byte;

    assign wp_q    = wp_sync_q[1];
    assign rd_byte = mem_q[word_addr_q];
    assign write_busy = busy_cnt_q != 16'h0000;
    assign committing = stop_det & (page_cnt_q != 4'h0) & ~write_busy;

    // byte engine: bit count, shift, ack and read phases
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_q     <= nvw_pkg::NVW_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            ack_phase_q <= 1'b0;
            read_seq_q  <= 1'b0;
            sda_drive_q <= 1'b0;
        end
        else if (write_busy)
        begin
            state_q     <= nvw_pkg::NVW_IDLE;
            sda_drive_q <= 1'b0;
        end
        else if (start_det)
        begin
            state_q     <= nvw_pkg::NVW_DEVADDR;
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_drive_q <= 1'b0;
        end
        else if (stop_det)
        begin
            state_q     <= nvw_pkg::NVW_IDLE;
            read_seq_q  <= 1'b0;
            sda_drive_q <= 1'b0;
        end
        else if (scl_rise && state_q != nvw_pkg::NVW_IDLE
                 && state_q != nvw_pkg::NVW_IGNORE)
        begin
            if (!ack_phase_q)
            begin
                shift_q   <= {shift_q[6:0], sda_sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (state_q == nvw_pkg::NVW_RACK && sda_sync_q[1])
                state_q <= nvw_pkg::NVW_IGNORE;            // master nak
        end
        else if (scl_fall)
        begin
            if (ack_phase_q)
            begin
                // ninth pulse over: release or present next read byte
                ack_phase_q <= 1'b0;
                bit_cnt_q   <= 4'h0;
                if (state_q == nvw_pkg::NVW_RDATA
                    || state_q == nvw_pkg::NVW_RACK)
                begin
                    state_q     <= nvw_pkg::NVW_RDATA;
                    shift_q     <= rd_byte;
                    sda_drive_q <= ~rd_byte[7];
                end
                else
                    sda_drive_q <= 1'b0;
            end
            else if (state_q == nvw_pkg::NVW_RDATA && bit_cnt_q != 4'h8)
                sda_drive_q <= ~shift_q[7];
            else if (state_q == nvw_pkg::NVW_RDATA)
            begin
                // byte sent; release for master acknowledge
                sda_drive_q <= 1'b0;
                ack_phase_q <= 1'b1;
                state_q     <= nvw_pkg::NVW_RACK;
            end
            else if (bit_cnt_q == 4'h8)
            begin
                unique case (state_q)
                    nvw_pkg::NVW_DEVADDR:
                    begin
                        if (shift_q[7:4] == nvw_pkg::DEV_TYPE
                            && shift_q[3:1] == sel_sync2_q)
                        begin
                            ack_phase_q <= 1'b1;
                            sda_drive_q <= 1'b1;
                            read_seq_q  <= shift_q[0];
                            state_q     <= shift_q[0]
                                         ? nvw_pkg::NVW_RDATA
                                         : nvw_pkg::NVW_WORDADDR;
                        end
                        else
                            state_q <= nvw_pkg::NVW_IGNORE; // standby
                    end
                    nvw_pkg::NVW_WORDADDR, nvw_pkg::NVW_WDATA:
                    begin
                        ack_phase_q <= 1'b1;
                        sda_drive_q <= 1'b1;
                        state_q     <= nvw_pkg::NVW_WDATA;
                    end
                    default:
                        state_q <= nvw_pkg::NVW_IGNORE;
                endcase
            end
            else if (state_q == nvw_pkg::NVW_RDATA)
                shift_q <= shift_q;
        end
    end

    //--------------------------------------------------------------
    // word address pointer and page staging
    //--------------------------------------------------------------
    logic byte_done;
    assign byte_done = scl_fall & ~ack_phase_q & (bit_cnt_q == 4'h8)
                     & ~write_busy & ~start_det & ~stop_det;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            word_addr_q <= 8'h00;
            page_cnt_q  <= 4'h0;
        end
        else if (start_det && !write_busy)
            page_cnt_q <= 4'h0;                            // abandon page
        else if (committing)
            page_cnt_q <= 4'h0;
        else if (byte_done && state_q == nvw_pkg::NVW_WORDADDR)
        begin
            word_addr_q <= shift_q;
            page_cnt_q  <= 4'h0;
        end
        else if (byte_done && state_q == nvw_pkg::NVW_WDATA)
        begin
            if (page_cnt_q != 4'(nvw_pkg::PAGE_BYTES))
            begin
                page_q[page_cnt_q[2:0]] <= '{addr: word_addr_q,
                                             data: shift_q};
                page_cnt_q <= page_cnt_q + 4'h1;
            end
            word_addr_q <= word_addr_q + 8'h01;
        end
        else if (scl_rise && state_q == nvw_pkg::NVW_RACK
                 && ack_phase_q)
            word_addr_q <= word_addr_q + 8'h01;
    end

    //--------------------------------------------------------------
    // commit on stop and self-timed write
    //--------------------------------------------------------------
    logic [7:0] sel_now;
    logic       prot_pin;
    assign sel_now  = mem_q[nvw_pkg::REGION_SEL_OFS];
    assign prot_pin = wp_q;

    // apply staged bytes through protection
    always_ff @(posedge sys_clk)
    begin
        if (committing && !prot_pin)
        begin
            for (int i = 0; i < nvw_pkg::PAGE_BYTES; i++)
            begin
                if (4'(i) < page_cnt_q
                    && !is_guarded(page_q[i].addr, sel_now, locked_q))
                    mem_q[page_q[i].addr] <= page_q[i].data;
            end
        end
    end

    // lock state evaluated after each commit the protect pin lets through
    logic [7:0] key1, key2;
    assign key1 = mem_q[nvw_pkg::LOCK_KEY1_OFS];
    assign key2 = mem_q[nvw_pkg::LOCK_KEY2_OFS];
    logic commit_done_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            locked_q      <= 1'b0;
            commit_done_q <= 1'b0;
        end
        else
        begin
            commit_done_q <= committing & ~prot_pin;
            // keys only land while the upper page is open
            if (commit_done_q)
            begin
                if (key1 == nvw_pkg::LOCK_PAT1
                    && key2 == nvw_pkg::LOCK_PAT2)
                    locked_q <= 1'b1;
                else if (key1 == nvw_pkg::UNLOCK_PAT1
                         && key2 == nvw_pkg::UNLOCK_PAT2)
                    locked_q <= 1'b0;
            end
        end
    end
    // lower guards sit in the page region, so they move unless locked with the page guard set

    // busy timer for the internal write
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            busy_cnt_q <= 16'h0000;
        else if (committing)
            busy_cnt_q <= 16'(WRITE_CYCLES);
        else if (write_busy)
            busy_cnt_q <= busy_cnt_q - 16'h0001;
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    logic [6:0] narrow_q;
    logic [7:0] wide_q;
    logic       standby_q;

    // narrow position: msb dropped, anything past the top step clamps
    function automatic logic [6:0] narrow_pos(input logic [7:0] b);
        return (b[6:0] > nvw_pkg::NARROW_MAX[6:0])
             ? nvw_pkg::NARROW_MAX[6:0] : b[6:0];
    endfunction

    // wipers take setting bytes as they commit, so an array that
    // holds no known bytes after reset never reaches the outputs
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            narrow_q  <= 7'h00;
            wide_q    <= 8'h00;
            standby_q <= 1'b1;
        end
        else
        begin
            if (committing && !prot_pin)
            begin
                for (int i = 0; i < nvw_pkg::PAGE_BYTES; i++)
                begin
                    if (4'(i) < page_cnt_q
                        && !is_guarded(page_q[i].addr, sel_now,
                                       locked_q))
                    begin
                        if (page_q[i].addr == nvw_pkg::WIDE_WIPER_OFS)
                            wide_q <= page_q[i].data;
                        else if (page_q[i].addr
                                 == nvw_pkg::NARROW_WIPER_OFS)
                            narrow_q <= narrow_pos(page_q[i].data);
                    end
                end
            end
            standby_q <= (state_q == nvw_pkg::NVW_IDLE
                          || state_q == nvw_pkg::NVW_IGNORE)
                         && !write_busy;
        end
    end

    assign narrow_wiper_out = narrow_q;
    assign wide_wiper_out   = wide_q;
    assign standby          = standby_q;
    assign sda_out          = 1'b0;
    assign sda_oe_n         = ~sda_drive_q;
endmodule

// ==== sim/nvw_chk.sv ====
// port-level assertions for the wiper memory block
`timescale 1ns/1ps
module nvw_chk #(
    parameter int WRITE_CYCLES = nvw_pkg::WRITE_CYCLES
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rstn,
    // two-wire link
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    // strap and protect pins
    input wire logic       addr_select_bit0,
    input wire logic       addr_select_bit1,
    input wire logic       addr_select_bit2,
    input wire logic       write_protect,
    // wipers and status
    input wire logic [6:0] narrow_wiper_out,
    input wire logic [7:0] wide_wiper_out,
    input wire logic       standby,
    input wire logic       write_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // helper
    // ----------------------------------------
    // length of the running internal write
    int busy_cnt_q;
    always_ff @(posedge sys_clk)
    begin
        if (!rstn || !write_busy)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
    end
    // a pulled bit lasts one full bit time
    sequence s_pull_low;
        !sda_oe_n [*8];
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_drive_low_only: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_narrow_clamp: assert property (narrow_wiper_out <= 7'h63)
        else $error("narrow wiper above top position");
    a_ack_stands: assert property ($fell(sda_oe_n) |-> s_pull_low)
        else $error("pulled bit shorter than a bit time");
    a_busy_no_ack: assert property (write_busy |-> sda_oe_n)
        else $error("line pulled during internal write");
    a_busy_length:
        assert property ($fell(write_busy) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("internal write of wrong length");
    a_busy_awake: assert property (write_busy |-> !standby)
        else $error("standby during internal write");
    a_pull_awake: assert property (!sda_oe_n |-> !standby)
        else $error("line pulled while in standby");
    a_pin_blocks:
        assert property (write_protect |->
            $stable(wide_wiper_out) && $stable(narrow_wiper_out))
        else $error("wiper moved while protect pin high");
    a_wiper_commit:
        assert property ($changed(wide_wiper_out) ||
            $changed(narrow_wiper_out) |-> ##[0:3] write_busy)
        else $error("wiper moved outside a commit");
endmodule

// ==== sim/nvw_master.sv ====
// two-wire bus master model: drives clock, pulls or releases data
`timescale 1ns/1ps
module nvw_master (
    // clock
    input  wire logic sys_clk,
    // wire level and pace
    input  wire logic sda_wire,
    input  wire logic slow,
    // master drive
    output logic      scl,
    output logic      sda_drv
);
    logic idle = 1'b1;
    // clock stands high and data released outside frames
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // hold both lines for q quarter bits, doubled when slow
    task automatic ph(input logic c, input logic d, input int q);
        scl = c;
        sda_drv = d;
        repeat (slow ? 4 * q : 2 * q) @(negedge sys_clk);
    endtask
    // data changes only in the low phase, sampled late in the high
    task automatic bit_x(input logic b, output logic r);
        ph(1'b0, sda_drv, 1);
        ph(1'b0, b, 1);
        ph(1'b1, b, 2);
        r = sda_wire;
    endtask
    // start from idle or as a repeated start inside a frame
    task automatic start_c();
        if (!idle)
        begin
            ph(1'b0, sda_drv, 1);
            ph(1'b0, 1'b1, 1);
        end
        ph(1'b1, 1'b1, 2);
        ph(1'b1, 1'b0, 2);
        idle = 1'b0;
    endtask
    // data rises with clock high, bus left idle
    task automatic stop_c();
        ph(1'b0, sda_drv, 1);
        ph(1'b0, 1'b0, 1);
        ph(1'b1, 1'b0, 2);
        ph(1'b1, 1'b1, 2);
        idle = 1'b1;
    endtask
    // eight bits msb first, then the ninth bit both ways
    task automatic xfer(input logic [7:0] v, input logic b9,
                        output logic [7:0] got, output logic r9);
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], got[i]);
        bit_x(b9, r9);
    endtask
    // nine released clocks, then start and stop
    task automatic recover();
        logic r;
        repeat (9) bit_x(1'b1, r);
        start_c();
        stop_c();
    endtask
endmodule

// ==== sim/nvw_top_tb.sv ====
// self-checking bench for the wiper memory block
`timescale 1ns/1ps
module nvw_top_tb;
    localparam int         WCYC = 200;
    localparam logic [2:0] SEL  = 3'h5;
    logic       sys_clk = 1'b0;
    logic       rstn    = 1'b0;
    logic       wp      = 1'b0;
    logic       slow    = 1'b0;
    logic       scl, sda_drv, sda_wire, sda_out, sda_oe_n;
    logic       standby, write_busy, k;
    logic [6:0] narrow;
    logic [7:0] wide, v, nv;
    logic [7:0] exp_mem [256];
    logic [7:0] tab [4] = '{8'h85, 8'h63, 8'h64, 8'he4};
    int         n_mismatch  = 0;
    int         checks_done = 0;
    // clock and open-drain wire with pull-up
    always #5 sys_clk = ~sys_clk;
    assign sda_wire = sda_drv & (sda_oe_n | sda_out);
    nvw_top #(.WRITE_CYCLES(WCYC)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_bit0(SEL[0]), .addr_select_bit1(SEL[1]),
        .addr_select_bit2(SEL[2]), .write_protect(wp),
        .narrow_wiper_out(narrow), .wide_wiper_out(wide),
        .standby(standby), .write_busy(write_busy));
    nvw_master m (.sys_clk(sys_clk), .sda_wire(sda_wire), .slow(slow),
        .scl(scl), .sda_drv(sda_drv));
    // compare, count and report
    task automatic check(input string s, input logic [7:0] g, e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] dev(input logic rd);
        return {nvw_pkg::DEV_TYPE, SEL, rd};
    endfunction
    // write bytes, poll during the internal write, wait for its end
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$],
                      input logic ok);
        m.start_c();
        m.xfer(dev(1'b0), 1'b1, v, k);
        check("dev ack", {7'h0, k}, 8'h00);
        m.xfer(a, 1'b1, v, k);
        foreach (d[i])
        begin
            m.xfer(d[i], 1'b1, v, k);
            check("data ack", {7'h0, k}, 8'h00);
            if (ok && i < nvw_pkg::PAGE_BYTES)
                exp_mem[a + 8'(i)] = d[i];
        end
        m.stop_c();
        m.start_c();
        m.xfer(dev(1'b0), 1'b1, v, k);
        check("busy poll", {7'h0, k}, 8'h01);
        m.stop_c();
        for (int i = 0; i < 300 && write_busy !== 1'b0; i++)
            @(negedge sys_clk);
        check("busy end", {7'h0, write_busy}, 8'h00);
    endtask
    // random then sequential read, nak on the last byte
    task automatic rd(input logic [7:0] a, input int n);
        m.start_c();
        m.xfer(dev(1'b0), 1'b1, v, k);
        m.xfer(a, 1'b1, v, k);
        m.start_c();
        m.xfer(dev(1'b1), 1'b1, v, k);
        for (int i = 0; i < n; i++)
        begin
            m.xfer(8'hff, i == n - 1, v, k);
            check("read", v, exp_mem[a + 8'(i)]);
        end
        m.stop_c();
        repeat (8) @(negedge sys_clk);
        check("standby", {7'h0, standby}, 8'h01);
    endtask
    // wiper outputs against the stored settings
    task automatic wipers();
        nv = exp_mem[8'hf9] & 8'h7f;
        if (nv > nvw_pkg::NARROW_MAX)
            nv = nvw_pkg::NARROW_MAX;
        check("narrow", {1'b0, narrow}, nv);
        check("wide", wide, exp_mem[8'hf8]);
    endtask
    // main sequence
    initial
    begin
        exp_mem[8'hf8] = 8'h00;
        exp_mem[8'hf9] = 8'h00;
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("idle", {7'h0, sda_oe_n}, 8'h01);
        check("standby", {7'h0, standby}, 8'h01);
        wipers();
        wr(8'h28, '{8'h5a}, 1'b1);
        wr(8'h20, '{1, 2, 3, 4, 5, 6, 7, 8, 9}, 1'b1);
        rd(8'h20, 9);
        slow = 1'b1;
        wr(8'hff, '{8'hc1, 8'hc2}, 1'b1);
        rd(8'hff, 2);
        slow = 1'b0;
        foreach (tab[i])
        begin
            wr(8'hf8, '{~tab[i], tab[i]}, 1'b1);
            wipers();
        end
        wr(8'h10, '{8'h33}, 1'b1);
        wp = 1'b1;
        wr(8'hf8, '{8'h11, 8'h22}, 1'b0);
        wr(8'h10, '{8'hee}, 1'b0);
        wp = 1'b0;
        wipers();
        wr(8'hfa, '{8'h01, 8'h56, 8'h25}, 1'b1);
        wr(8'h10, '{8'h44}, 1'b0);
        wr(8'h90, '{8'h45}, 1'b1);
        wr(8'hfb, '{8'h67, 8'h36}, 1'b1);
        wr(8'h10, '{8'h46}, 1'b1);
        wr(8'hfa, '{8'h06, 8'h56, 8'h25}, 1'b1);
        wr(8'h90, '{8'h47}, 1'b0);
        wr(8'hf8, '{8'h48}, 1'b0);
        wr(8'hfa, '{8'h00, 8'h67, 8'h36}, 1'b0);
        wr(8'h90, '{8'h49}, 1'b0);
        wr(8'h10, '{8'h4a}, 1'b1);
        rd(8'h10, 1);
        rd(8'h90, 1);
        rd(8'hf8, 5);
        wipers();
        m.start_c();
        m.xfer({nvw_pkg::DEV_TYPE, ~SEL, 1'b0}, 1'b1, v, k);
        check("select", {7'h0, k}, 8'h01);
        m.recover();
        rstn = 1'b0;
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("wide", wide, 8'h00);
        wr(8'h90, '{8'h4b}, 1'b1);
        rd(8'h90, 1);
        finish_test();
    end
    // watchdog against a hung link, over two and a half times the expected run
    initial
    begin
        #400000;
        n_mismatch++;
        finish_test();
    end
endmodule

bind nvw_top nvw_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_bit0(addr_select_bit0),
    .addr_select_bit1(addr_select_bit1),
    .addr_select_bit2(addr_select_bit2),
    .write_protect(write_protect), .narrow_wiper_out(narrow_wiper_out),
    .wide_wiper_out(wide_wiper_out), .standby(standby),
    .write_busy(write_busy));
